// File: pls_regs.vh
/*
 Constants for the lane sync and deterministic latency PCS block.
 Assumes inclusion by bare name from the design files of this folder.
*/
`ifndef PLS_REGS_VH
`define PLS_REGS_VH
`define PLS_ACQ_COUNT     3'h4
`define PLS_ERR_LIMIT     3'h4
`define PLS_GOOD_RUN      2'h3
`define PLS_COMMA_POS     10'h283
`define PLS_COMMA_NEG     10'h17C
`define PLS_COMMA7_MASK   10'h3F8
`define PLS_RX_LAT_SER    4'h5
`define PLS_RX_LAT_NOSER  4'h8
`define PLS_TX_LAT_SER    4'h2
`define PLS_TX_LAT_NOSER  4'h4
`define PLS_FIFO_DEPTH    16
`define PLS_FIFO_AW       4
`endif

// File: pls_fifo.v
/*
 Phase compensation FIFO, width and depth by parameter.
 Assumes one clock; registered mode bypasses storage with one register.
*/
`timescale 1ns/1ps
module pls_fifo #(
	parameter WIDTH = 20,
	parameter DEPTH = 16,
	parameter AW    = 4
)(
	// Clock and reset
	input  wire             clk,
	input  wire             reset_n,
	// Mode
	input  wire             reg_mode,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output reg              out_valid,
	input  wire             out_ready,
	output reg  [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr_r;
	reg [AW:0]      rd_ptr_r;
	wire            empty;
	wire            full;
	wire            do_wr;
	wire            do_rd;
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign in_ready = reg_mode ? (out_ready | ~out_valid) : ~full;
	assign do_wr = in_valid & in_ready & ~reg_mode;
	assign do_rd = ~empty & (out_ready | ~out_valid) & ~reg_mode;
	// Storage write
	always @(posedge clk)
	begin
		if (do_wr)
			mem[wr_ptr_r[AW-1:0]] <= in_data;
	end
	// Pointers and output register
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_r  <= {(AW+1){1'b0}};
			rd_ptr_r  <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data  <= {WIDTH{1'b0}};
		end
		else if (reg_mode)
		begin
			// Single stage, fixed latency, no variable depth
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
			if (out_ready | ~out_valid)
			begin
				out_valid <= in_valid;
				out_data  <= in_data;
			end
		end
		else
		begin
			if (do_wr)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (do_rd)
			begin
				rd_ptr_r  <= rd_ptr_r + 1'b1;
				out_data  <= mem[rd_ptr_r[AW-1:0]];
				out_valid <= 1'b1;
			end
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule

// File: pls_lane_pcs.v
/*
 Receive lane synchronisation and deterministic latency data paths.
 Assumes code groups arrive on clk already parallel, one per cycle
 with a valid strobe, and that sync inputs come from the same domain.
*/
`timescale 1ns/1ps
`include "pls_regs.vh"
module pls_lane_pcs (
	// Clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// Mode controls
	input  wire        xaui_mode,
	input  wire        comma_len7,
	input  wire        byte_serializer,
	input  wire        codec_bypass,
	input  wire        tx_reg_mode,
	input  wire        chan_aligned_in,
	// Receive code groups from the deserialiser
	input  wire [9:0]  rx_code,
	input  wire        rx_code_valid,
	input  wire        rx_code_err,
	// Receive fabric side
	input  wire [19:0] rx_word_in,
	input  wire        rx_word_in_valid,
	output reg  [19:0] rx_data,
	output reg         rx_data_valid,
	input  wire        rx_data_ready,
	// Transmit fabric side
	input  wire [19:0] tx_data,
	input  wire        tx_data_valid,
	output reg         tx_data_ready,
	output reg  [19:0] tx_word,
	output reg         tx_word_valid,
	// Status
	output reg         lane_synced,
	output reg         chan_aligned,
	output reg  [3:0]  rx_latency,
	output reg  [3:0]  tx_latency,
	output reg  [4:0]  fabric_width
);
	localparam ST_LOSS = 3'b001;
	localparam ST_ACQ  = 3'b010;
	localparam ST_SYNC = 3'b100;

	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [2:0]  comma_cnt_r;
	reg  [2:0]  comma_cnt_nxt;
	reg  [2:0]  err_cnt_r;
	reg  [2:0]  err_cnt_nxt;
	reg  [1:0]  good_cnt_r;
	reg  [1:0]  good_cnt_nxt;
	reg  [19:0] rx_pipe_r [0:7];
	reg  [7:0]  rx_vpipe_r;
	reg  [59:0] tx_stage_r;
	reg  [2:0]  tx_stage_v_r;
	wire        comma;
	wire        fifo_in_ready;
	wire        fifo_out_valid;
	wire [19:0] fifo_out_data;
	wire [2:0]  rx_tap;
	wire        tx_fifo_v;
	wire [19:0] tx_fifo_d;
	integer     i;

	// Comma match on 7-bit or 10-bit pattern
	function is_comma;
		input [9:0] code;
		input       len7;
		reg   [9:0] m;
		begin
			m = len7 ? `PLS_COMMA7_MASK : 10'h3FF;
			is_comma = ((code & m) == (`PLS_COMMA_POS & m)) || ((code & m) == (`PLS_COMMA_NEG & m));
		end
	endfunction

	assign comma = is_comma(rx_code, comma_len7);

	//--------------------------------------------------------------
	// Lane synchronisation state machine
	//--------------------------------------------------------------
	// Next state: loss, acquire, synced with error accounting
	always @*
	begin
		state_nxt     = state_r;
		comma_cnt_nxt = comma_cnt_r;
		err_cnt_nxt   = err_cnt_r;
		good_cnt_nxt  = good_cnt_r;
		if (!xaui_mode)
		begin
			state_nxt     = ST_LOSS;
			comma_cnt_nxt = 3'h0;
			err_cnt_nxt   = 3'h0;
			good_cnt_nxt  = 2'h0;
		end
		else if (rx_code_valid)
		begin
			case (state_r)
				ST_LOSS:
				begin
					comma_cnt_nxt = 3'h0;
					if (comma && !rx_code_err)
					begin
						state_nxt     = ST_ACQ;
						comma_cnt_nxt = 3'h1;
					end
				end
				ST_ACQ:
				begin
					if (rx_code_err)
						state_nxt = ST_LOSS;
					else if (comma)
					begin
						if (comma_cnt_r + 3'h1 == `PLS_ACQ_COUNT)
						begin
							state_nxt    = ST_SYNC;
							err_cnt_nxt  = 3'h0;
							good_cnt_nxt = 2'h0;
						end
						else
							comma_cnt_nxt = comma_cnt_r + 3'h1;
					end
				end
				ST_SYNC:
				begin
					if (rx_code_err)
					begin
						good_cnt_nxt = 2'h0;
						if (err_cnt_r + 3'h1 == `PLS_ERR_LIMIT)
							state_nxt = ST_LOSS;
						else
							err_cnt_nxt = err_cnt_r + 3'h1;
					end
					else if (err_cnt_r != 3'h0)
					begin
						if (good_cnt_r == `PLS_GOOD_RUN)
						begin
							err_cnt_nxt  = err_cnt_r - 3'h1;
							good_cnt_nxt = 2'h0;
						end
						else
							good_cnt_nxt = good_cnt_r + 2'h1;
					end
				end
				default:
					state_nxt = ST_LOSS;
			endcase
		end
	end

	// State registers
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r     <= ST_LOSS;
			comma_cnt_r <= 3'h0;
			err_cnt_r   <= 3'h0;
			good_cnt_r  <= 2'h0;
			lane_synced <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			comma_cnt_r <= comma_cnt_nxt;
			err_cnt_r   <= err_cnt_nxt;
			good_cnt_r  <= good_cnt_nxt;
			lane_synced <= (state_nxt == ST_SYNC);
		end
	end

	//--------------------------------------------------------------
	// Receive path: fixed pipeline then registered compensation
	//--------------------------------------------------------------
	// Tap gives total 5 cycles serialised, 8 otherwise
	assign rx_tap = byte_serializer ? 3'h3 : 3'h6;

	// Fixed delay line ahead of the FIFO
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_vpipe_r <= 8'h00;
			for (i = 0; i < 8; i = i + 1)
				rx_pipe_r[i] <= 20'h00000;
		end
		else
		begin
			rx_vpipe_r <= {rx_vpipe_r[6:0], rx_word_in_valid};
			rx_pipe_r[0] <= rx_word_in;
			for (i = 1; i < 8; i = i + 1)
				rx_pipe_r[i] <= rx_pipe_r[i-1];
		end
	end

	// Receive FIFO forced into registered mode
	pls_fifo #(
		.WIDTH (20),
		.DEPTH (`PLS_FIFO_DEPTH),
		.AW    (`PLS_FIFO_AW)
	) u_rx_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.reg_mode  (1'b1),
		.in_valid  (rx_vpipe_r[rx_tap]),
		.in_ready  (),
		.in_data   (rx_pipe_r[rx_tap]),
		.out_valid (fifo_out_valid),
		.out_ready (rx_data_ready),
		.out_data  (fifo_out_data)
	);

	// Receive output register
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_data       <= 20'h00000;
			rx_data_valid <= 1'b0;
		end
		else
		begin
			rx_data       <= fifo_out_data;
			rx_data_valid <= fifo_out_valid;
		end
	end

	//--------------------------------------------------------------
	// Transmit path: optional registered mode
	//--------------------------------------------------------------
	// Transmit FIFO with selectable registered mode
	pls_fifo #(
		.WIDTH (20),
		.DEPTH (`PLS_FIFO_DEPTH),
		.AW    (`PLS_FIFO_AW)
	) u_tx_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.reg_mode  (tx_reg_mode),
		.in_valid  (tx_data_valid & tx_data_ready),
		.in_ready  (fifo_in_ready),
		.in_data   (tx_data),
		.out_valid (tx_fifo_v),
		.out_ready (1'b1),
		.out_data  (tx_fifo_d)
	);

	// Delay line: 3 cycles serialised, 4 without, FIFO mode one more
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_stage_r    <= 60'h000000000000000;
			tx_stage_v_r  <= 3'h0;
			tx_word       <= 20'h00000;
			tx_word_valid <= 1'b0;
			tx_data_ready <= 1'b0;
		end
		else
		begin
			tx_data_ready <= fifo_in_ready;
			tx_stage_r    <= {tx_stage_r[39:0], tx_fifo_d};
			tx_stage_v_r  <= {tx_stage_v_r[1:0], tx_fifo_v};
			tx_word       <= byte_serializer ? tx_stage_r[39:20] : tx_stage_r[59:40];
			tx_word_valid <= byte_serializer ? tx_stage_v_r[1] : tx_stage_v_r[2];
		end
	end

	//--------------------------------------------------------------
	// Status outputs
	//--------------------------------------------------------------
	// Alignment, latency and fabric width reporting
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			chan_aligned <= 1'b0;
			rx_latency   <= 4'h0;
			tx_latency   <= 4'h0;
			fabric_width <= 5'h00;
		end
		else
		begin
			chan_aligned <= chan_aligned_in;
			rx_latency   <= byte_serializer ? `PLS_RX_LAT_SER : `PLS_RX_LAT_NOSER;
			tx_latency   <= byte_serializer ? `PLS_TX_LAT_SER : `PLS_TX_LAT_NOSER;
			// 16/8 with codec, 20/10 bypassed
			fabric_width <= byte_serializer ? (codec_bypass ? 5'h14 : 5'h10) : (codec_bypass ? 5'h0A : 5'h08);
		end
	end
endmodule

// File: pls_link_partner.sv
/*
 Link partner model: feeds code groups to the lane sync input.
 Assumes the bench calls send from one process.
*/
`timescale 1ns/1ps
module pls_link_partner (
	// Clock
	input  wire       clk,
	// Code group stream
	output reg  [9:0] rx_code,
	output reg        rx_code_valid,
	output reg        rx_code_err
);
	// Idle until told to send
	initial
	begin
		rx_code = 10'h000;
		rx_code_valid = 1'b0;
		rx_code_err = 1'b0;
	end
	// Groups on falling edges, then idle on a changed pattern
	task send(input logic [9:0] code, input logic err, input int n);
		repeat (n)
		begin
			@(negedge clk);
			rx_code = code;
			rx_code_valid = 1'b1;
			rx_code_err = err;
		end
		@(negedge clk);
		rx_code_valid = 1'b0;
		rx_code_err = 1'b0;
		rx_code = ~code; // Idle lines never hold the last group
	endtask
endmodule

// File: pls_lane_asserts.sv
/*
 Port checker for the lane sync and fixed latency block.
 Assumes one clock domain; bound to the top module below.
*/
`timescale 1ns/1ps
module pls_lane_asserts (
	// Clock and modes
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       xaui_mode,
	input wire logic       byte_serializer,
	input wire logic       codec_bypass,
	input wire logic       tx_reg_mode,
	// Streams
	input wire logic       rx_code_valid,
	input wire logic       rx_code_err,
	input wire logic       rx_word_in_valid,
	input wire logic       rx_data_valid,
	input wire logic       tx_data_valid,
	input wire logic       tx_data_ready,
	input wire logic       tx_word_valid,
	// Status
	input wire logic       lane_synced,
	input wire logic [3:0] rx_latency,
	input wire logic [3:0] tx_latency,
	input wire logic [4:0] fabric_width
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Lane sync cause and effect
	mode_off_a: assert property (!xaui_mode |=> !lane_synced)
		else $error("sync while lane machine off");
	sync_cause_a: assert property ($rose(lane_synced) |-> $past(rx_code_valid && !rx_code_err && xaui_mode))
		else $error("sync rose without a clean group");
	sync_drop_a: assert property ($fell(lane_synced) |-> $past(!xaui_mode || (rx_code_valid && rx_code_err)))
		else $error("sync dropped without an error");
	// Informational outputs follow the modes
	width_info_a: assert property ($stable({codec_bypass, byte_serializer})[*2] |->
		fabric_width == ((codec_bypass ? 5'h0A : 5'h08) << byte_serializer)
		&& rx_latency == (byte_serializer ? 4'h5 : 4'h8) && tx_latency == (byte_serializer ? 4'h2 : 4'h4))
		else $error("width or latency report wrong");
	// Fixed path latencies
	rx_ser_a: assert property (rx_word_in_valid && byte_serializer |-> ##[6:7] rx_data_valid)
		else $error("rx word late with serializer");
	rx_noser_a: assert property (rx_word_in_valid && !byte_serializer |-> ##[9:10] rx_data_valid)
		else $error("rx word late without serializer");
	tx_ser_a: assert property (tx_data_valid && tx_data_ready && byte_serializer && tx_reg_mode |->
		##4 tx_word_valid) else $error("tx word late with serializer");
	tx_noser_a: assert property (tx_data_valid && tx_data_ready && !byte_serializer |-> ##[5:6] tx_word_valid)
		else $error("tx word late without serializer");
endmodule
bind pls_lane_pcs pls_lane_asserts u_pls_lane_asserts (.clk, .reset_n, .xaui_mode, .byte_serializer, .codec_bypass,
	.tx_reg_mode, .rx_code_valid, .rx_code_err, .rx_word_in_valid, .rx_data_valid, .tx_data_valid, .tx_data_ready,
	.tx_word_valid, .lane_synced, .rx_latency, .tx_latency, .fabric_width);

// File: pls_lane_pcs_tb.sv
/*
 Self-checking bench for the lane sync and fixed latency block.
 Assumes the partner model and the checker compile first.
*/
`timescale 1ns/1ps
`include "pls_regs.vh"
module pls_lane_pcs_tb;
	// Inputs, changed on falling edges
	reg        clk = 1'b0, reset_n = 1'b0, xaui_mode = 1'b0, comma_len7 = 1'b0;
	reg        byte_serializer = 1'b1, codec_bypass = 1'b0, tx_reg_mode = 1'b1, chan_aligned_in = 1'b0;
	reg        rx_word_in_valid = 1'b0, tx_data_valid = 1'b0;
	reg [19:0] rx_word_in = 20'h00000, tx_data = 20'h00000;
	// Outputs
	wire [9:0] rx_code;
	wire       rx_code_valid, rx_code_err, rx_data_valid, tx_data_ready, tx_word_valid, lane_synced, chan_aligned;
	wire [19:0] rx_data, tx_word;
	wire [3:0] rx_latency, tx_latency;
	wire [4:0] fabric_width;
	int        n_fail = 0;
	int        checks_done = 0;
	always #2.5 clk = ~clk;
	pls_link_partner u_pls_link_partner (.clk, .rx_code, .rx_code_valid, .rx_code_err);
	pls_lane_pcs u_pls_lane_pcs (.clk, .reset_n, .xaui_mode, .comma_len7, .byte_serializer, .codec_bypass, .tx_reg_mode,
		.chan_aligned_in, .rx_code, .rx_code_valid, .rx_code_err, .rx_word_in, .rx_word_in_valid, .rx_data,
		.rx_data_valid, .rx_data_ready(1'b1), .tx_data, .tx_data_valid, .tx_data_ready, .tx_word, .tx_word_valid,
		.lane_synced, .chan_aligned, .rx_latency, .tx_latency, .fabric_width);
	// Compare and count
	task chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task conclude;
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Bounded wait for a valid flag, counting cycles
	task wt(input logic tx, output int n);
		n = 0;
		while ((tx ? tx_word_valid : rx_data_valid) !== 1'b1)
		begin
			@(negedge clk);
			n++;
			if (n > 20)
			begin
				chk("timeout", 20'h0, 20'h1);
				conclude();
			end
		end
	endtask
	task sg(input logic [9:0] code, input logic err, input int n);
		u_pls_link_partner.send(code, err, n);
		@(negedge clk);
	endtask
	// Machine off a cycle, then three and four commas
	task sync_acq(input logic [9:0] code, input logic len7, input logic exp);
		@(negedge clk);
		xaui_mode = 1'b0;
		comma_len7 = len7;
		@(negedge clk);
		xaui_mode = 1'b1;
		sg(code, 1'b0, 3);
		chk("sync_early", 20'h0, lane_synced);
		sg(code, 1'b0, 1);
		chk("sync", exp, lane_synced);
	endtask
	task sync_loss;
		sg(10'h155, 1'b1, 3);
		chk("err3", 20'h1, lane_synced);
		sg(10'h155, 1'b1, 1);
		chk("err4", 20'h0, lane_synced);
	endtask
	// Four good groups take one error back
	task good_run;
		sync_acq(`PLS_COMMA_NEG, 1'b0, 1'b1);
		sg(10'h155, 1'b1, 3);
		sg(10'h0AA, 1'b0, 4);
		sg(10'h155, 1'b1, 1);
		chk("run", 20'h1, lane_synced);
		sg(10'h155, 1'b1, 1);
		chk("run_end", 20'h0, lane_synced);
	endtask
	task rx_lat(input logic ser, input int lo);
		int n;
		@(negedge clk);
		byte_serializer = ser;
		repeat (12) @(negedge clk);
		rx_word_in = 20'hC3A50 ^ ser;
		rx_word_in_valid = 1'b1;
		@(negedge clk);
		rx_word_in_valid = 1'b0;
		wt(1'b0, n);
		chk("rx_lat", 20'h1, n >= lo && n <= lo + 1);
		chk("rx_data", 20'hC3A50 ^ ser, rx_data);
	endtask
	task tx_lat(input logic ser, input logic regm);
		int n;
		@(negedge clk);
		byte_serializer = ser;
		tx_reg_mode = regm;
		repeat (12) @(negedge clk);
		chk("tx_ready", 20'h1, tx_data_ready);
		tx_data = 20'h5B7E0 ^ {ser, regm};
		tx_data_valid = 1'b1;
		@(negedge clk);
		tx_data_valid = 1'b0;
		wt(1'b1, n);
		chk("tx_lat", 20'h1, n >= (ser ? 3 : 4) + !regm && n <= (ser ? 3 : 5) + !regm);
		chk("tx_word", 20'h5B7E0 ^ {ser, regm}, tx_word);
	endtask
	task widths;
		int i;
		for (i = 0; i < 4; i++)
		begin
			@(negedge clk);
			{codec_bypass, byte_serializer} = i[1:0];
			repeat (2) @(negedge clk);
			chk("width", (i[1] ? 20'hA : 20'h8) << i[0], fabric_width);
			chk("rx_latency", i[0] ? 20'h5 : 20'h8, rx_latency);
			chk("tx_latency", i[0] ? 20'h2 : 20'h4, tx_latency);
		end
	endtask
	task align;
		int i;
		for (i = 1; i >= 0; i--)
		begin
			@(negedge clk);
			chan_aligned_in = i[0];
			repeat (2) @(negedge clk);
			chk("aligned", i[0], chan_aligned);
		end
	endtask
	// Reset, then each scenario in turn
	initial
	begin
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		sync_acq(`PLS_COMMA_POS, 1'b0, 1'b1);
		sync_acq(`PLS_COMMA_POS ^ 10'h007, 1'b0, 1'b0);
		sync_acq(`PLS_COMMA_NEG ^ 10'h007, 1'b1, 1'b1);
		sync_loss();
		good_run();
		rx_lat(1'b1, 5);
		rx_lat(1'b0, 8);
		tx_lat(1'b1, 1'b1);
		tx_lat(1'b0, 1'b1);
		tx_lat(1'b1, 1'b0);
		widths();
		align();
		conclude();
	end
endmodule
